// [pifb_top.sv]
/*
 * Peripheral interrupt flag bank: three enable registers, three request
 * registers, global control, and a sticky status / mask pair driving
 * one level interrupt, all behind an AXI4-Lite slave.
 * Assumes event inputs come from logic on ref_clk_i.
 */
`default_nettype none

module pifb_top #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  ce_i,
	input  wire logic [7:0]            evt_one_i,
	input  wire logic [7:0]            evt_two_i,
	input  wire logic [7:0]            evt_three_i,
	output logic                       core_irq_o,
	output logic                       irq_o,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
	input  wire logic                  s_axi_awvalid_i,
	output logic                       s_axi_awready_o,
	input  wire logic [pifb_pkg::DATA_W-1:0] s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	input  wire logic                  s_axi_wvalid_i,
	output logic                       s_axi_wready_o,
	output logic [1:0]                 s_axi_bresp_o,
	output logic                       s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
	input  wire logic                  s_axi_arvalid_i,
	output logic                       s_axi_arready_o,
	output logic [pifb_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0]                 s_axi_rresp_o,
	output logic                       s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i
);
	import pifb_pkg::*;

	// Write channel state
	logic              aw_rdy_ff;
	logic              w_rdy_ff;
	logic              aw_full_ff;
	logic              w_full_ff;
	logic              bvalid_ff;
	logic [7:0]        wr_idx_ff;
	logic              wr_hi_ok_ff;
	logic [7:0]        wdata_ff;
	logic              wstrb0_ff;
	// Read channel state
	logic              ar_rdy_ff;
	logic              rvalid_ff;
	logic [DATA_W-1:0] rdata_ff;
	// Register state
	logic [7:0]        pie_one_ff;
	logic [7:0]        pie_two_ff;
	logic [7:0]        pie_three_ff;
	logic              gie_ff;
	logic              peripheral_irq_enable_ff;
	logic [EVT_W-1:0]  status_ff;
	logic [EVT_W-1:0]  mask_ff;
	logic              core_irq_ff;
	logic              irq_ff;
	logic [7:0]        pir_one;
	logic [7:0]        pir_two;
	logic [7:0]        pir_three;

	// Bus handshakes, frozen with the clock enable
	wire aw_hs = ce_i & s_axi_awvalid_i & aw_rdy_ff;
	wire w_hs  = ce_i & s_axi_wvalid_i & w_rdy_ff;
	wire b_hs  = ce_i & s_axi_bready_i & bvalid_ff;
	wire ar_hs = ce_i & s_axi_arvalid_i & ar_rdy_ff;
	wire r_hs  = ce_i & s_axi_rready_i & rvalid_ff;
	wire wr_go = ce_i & aw_full_ff & w_full_ff & ~bvalid_ff;

	// Only low byte lane carries register data
	wire wr_en = wr_go & wstrb0_ff & wr_hi_ok_ff;

	wire aw_hi_ok = ~|s_axi_awaddr_i[ADDR_W-1:IDX_HI+1];
	wire ar_hi_ok = ~|s_axi_araddr_i[ADDR_W-1:IDX_HI+1];
	wire [7:0] ar_idx = s_axi_araddr_i[IDX_HI:IDX_LO];

	// Write decode
	wire wr_pie_one   = wr_en & (wr_idx_ff == IDX_ENABLE_ONE);
	wire wr_pie_two   = wr_en & (wr_idx_ff == IDX_ENABLE_TWO);
	wire wr_pie_three = wr_en & (wr_idx_ff == IDX_ENABLE_THREE);
	wire wr_pir_one   = wr_en & (wr_idx_ff == IDX_REQ_ONE);
	wire wr_pir_two   = wr_en & (wr_idx_ff == IDX_REQ_TWO);
	wire wr_pir_three = wr_en & (wr_idx_ff == IDX_REQ_THREE);
	wire wr_global    = wr_en & (wr_idx_ff == IDX_GLOBAL_CTRL);
	wire wr_mask      = wr_en & (wr_idx_ff == IDX_IRQ_MASK);

	// Read decode; anything else answers zero
	wire [7:0] rd_byte =
		~ar_hi_ok                      ? 8'h00 :
		(ar_idx == IDX_ENABLE_ONE)     ? pie_one_ff :
		(ar_idx == IDX_ENABLE_TWO)     ? pie_two_ff :
		(ar_idx == IDX_ENABLE_THREE)   ? pie_three_ff :
		(ar_idx == IDX_REQ_ONE)        ? pir_one :
		(ar_idx == IDX_REQ_TWO)        ? pir_two :
		(ar_idx == IDX_REQ_THREE)      ? pir_three :
		(ar_idx == IDX_GLOBAL_CTRL)    ? {gie_ff, peripheral_irq_enable_ff, 6'h00} :
		(ar_idx == IDX_IRQ_STATUS)     ? {5'h00, status_ff} :
		(ar_idx == IDX_IRQ_MASK)       ? {5'h00, mask_ff} :
		8'h00;
	wire rd_status = ar_hs & ar_hi_ok & (ar_idx == IDX_IRQ_STATUS);

	// Implemented events per request register
	wire [EVT_W-1:0] new_evt = {|(evt_three_i & IMPL_THREE),
		|(evt_two_i & IMPL_TWO), |(evt_one_i & IMPL_ONE)};
	// Read clears status, but a same-cycle event survives
	wire [EVT_W-1:0] nxt_status = (rd_status ? RST_STATUS : status_ff)
		| new_evt;

	wire pend_any = |(pir_one & pie_one_ff) | |(pir_two & pie_two_ff)
		| |(pir_three & pie_three_ff);
	wire nxt_core_irq = gie_ff & peripheral_irq_enable_ff & pend_any;
	wire nxt_irq = |(status_ff & mask_ff);

	// Request flag registers
	pifb_flag_reg #(
		.IMPL(IMPL_ONE)
	) u_req_one (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.evt_i     (evt_one_i),
		.wr_i      (wr_pir_one),
		.wdata_i   (wdata_ff),
		.flag_o    (pir_one)
	);

	pifb_flag_reg #(
		.IMPL(IMPL_TWO)
	) u_req_two (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.evt_i     (evt_two_i),
		.wr_i      (wr_pir_two),
		.wdata_i   (wdata_ff),
		.flag_o    (pir_two)
	);

	pifb_flag_reg #(
		.IMPL(IMPL_THREE)
	) u_req_three (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.evt_i     (evt_three_i),
		.wr_i      (wr_pir_three),
		.wdata_i   (wdata_ff),
		.flag_o    (pir_three)
	);

	// Write address / data capture; either may arrive first
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_rdy_ff   <= 1'b1;
			aw_full_ff  <= 1'b0;
			wr_idx_ff   <= 8'h00;
			wr_hi_ok_ff <= 1'b0;
		end else if (aw_hs) begin
			aw_rdy_ff   <= 1'b0;
			aw_full_ff  <= 1'b1;
			wr_idx_ff   <= s_axi_awaddr_i[IDX_HI:IDX_LO];
			wr_hi_ok_ff <= aw_hi_ok;
		end else if (wr_go) begin
			aw_full_ff  <= 1'b0;
		end else if (b_hs) begin
			aw_rdy_ff   <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			w_rdy_ff  <= 1'b1;
			w_full_ff <= 1'b0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (w_hs) begin
			w_rdy_ff  <= 1'b0;
			w_full_ff <= 1'b1;
			wdata_ff  <= s_axi_wdata_i[REG_W-1:0];
			wstrb0_ff <= s_axi_wstrb_i[0];
		end else if (wr_go) begin
			w_full_ff <= 1'b0;
		end else if (b_hs) begin
			w_rdy_ff  <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bvalid_ff <= 1'b0;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
		end else if (b_hs) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ar_rdy_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
		end else if (ar_hs) begin
			ar_rdy_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h00_0000, rd_byte};
		end else if (r_hs) begin
			ar_rdy_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// Enable and global control registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pie_one_ff   <= RST_ENABLE;
			pie_two_ff   <= RST_ENABLE;
			pie_three_ff <= RST_ENABLE;
			gie_ff       <= RST_GLOBAL[GLOBAL_EN_BIT];
			peripheral_irq_enable_ff      <= RST_GLOBAL[PERIPH_EN_BIT];
		end else if (ce_i) begin
			if (wr_pie_one) begin
				pie_one_ff <= wdata_ff & IMPL_ONE;
			end
			if (wr_pie_two) begin
				pie_two_ff <= wdata_ff & IMPL_TWO;
			end
			if (wr_pie_three) begin
				pie_three_ff <= wdata_ff & IMPL_THREE;
			end
			if (wr_global) begin
				gie_ff  <= wdata_ff[GLOBAL_EN_BIT];
				peripheral_irq_enable_ff <= wdata_ff[PERIPH_EN_BIT];
			end
		end
	end

	// Sticky status, mask and the two interrupt outputs
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_ff   <= RST_STATUS;
			mask_ff     <= RST_MASK;
			core_irq_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else if (ce_i) begin
			status_ff   <= nxt_status;
			if (wr_mask) begin
				mask_ff <= wdata_ff[EVT_W-1:0];
			end
			core_irq_ff <= nxt_core_irq;
			irq_ff      <= nxt_irq;
		end
	end

	assign s_axi_awready_o = aw_rdy_ff;
	assign s_axi_wready_o  = w_rdy_ff;
	assign s_axi_bvalid_o  = bvalid_ff;
	assign s_axi_bresp_o   = AXI_OKAY;
	assign s_axi_arready_o = ar_rdy_ff;
	assign s_axi_rvalid_o  = rvalid_ff;
	assign s_axi_rdata_o   = rdata_ff;
	assign s_axi_rresp_o   = AXI_OKAY;
	assign core_irq_o      = core_irq_ff;
	assign irq_o           = irq_ff;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_event_sets_flag: assert property (
		ce_i && evt_two_i[CMP_ONE_BIT] |=> pir_two[CMP_ONE_BIT])
		else $error("Comparator one event did not set its flag");

	a_cmp_two_readback: assert property (
		ar_hs && ar_hi_ok && ar_idx == IDX_REQ_TWO
		|=> s_axi_rdata_o[CMP_TWO_BIT] == $past(pir_two[CMP_TWO_BIT])
		&& s_axi_rdata_o[CMP_ONE_BIT] == $past(pir_two[CMP_ONE_BIT]))
		else $error("Comparator flags read back in wrong bits");

	a_unmapped_zero: assert property (
		ar_hs && (!ar_hi_ok || ar_idx == 8'h90) |=> s_axi_rdata_o == '0)
		else $error("Unmapped address did not read zero");

	a_unimpl_bits_zero: assert property (
		(pir_two & ~IMPL_TWO) == 8'h00 && (pie_one_ff & ~IMPL_ONE) == 8'h00)
		else $error("Unimplemented bit became set");

	a_reset_values: assert property (
		$past(sys_rst_i) |-> pir_two == 8'h00 && pie_one_ff == 8'h00
		&& pie_two_ff == 8'h00 && pie_three_ff == 8'h00)
		else $error("Flags or enables not zero after reset");

	a_core_irq_raise: assert property (
		ce_i && gie_ff && peripheral_irq_enable_ff && pend_any |=> core_irq_o)
		else $error("Core request missing while enabled and pending");

	a_core_irq_gated: assert property (
		ce_i && !(gie_ff && peripheral_irq_enable_ff) ##1 ce_i |-> !core_irq_o)
		else $error("Core request raised with globals off");

	a_set_beats_clear: assert property (
		wr_pir_two && !wdata_ff[CMP_ONE_BIT] && evt_two_i[CMP_ONE_BIT]
		|=> pir_two[CMP_ONE_BIT])
		else $error("Clear swallowed a concurrent event");

	a_flag_sticky: assert property (
		ce_i && pir_two[CMP_ONE_BIT] && !wr_pir_two
		|=> pir_two[CMP_ONE_BIT])
		else $error("Flag cleared without a software write");

	a_write_answer: assert property (
		wr_go |=> s_axi_bvalid_o && !aw_full_ff && !w_full_ff)
		else $error("Write answer did not follow the write");

	c_flag_cleared: cover property (
		wr_pir_two && !wdata_ff[CMP_ONE_BIT] ##1 !pir_two[CMP_ONE_BIT]);
	c_core_irq: cover property ($rose(core_irq_o));
	c_status_read: cover property (rd_status && status_ff != '0);

endmodule // pifb_top

`default_nettype wire

// [pifb_pkg.sv]
/*
 * Constants of the peripheral interrupt flag bank: register indices,
 * implemented-bit masks, reset values and bus answer codes.
 * Assumes a 32-bit AXI4-Lite register bus; byte address = 4 * index.
 */
`default_nettype none

package pifb_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;
	localparam int unsigned IDX_LO = 2;
	localparam int unsigned IDX_HI = 9;

	// Register indices
	localparam logic [7:0] IDX_GLOBAL_CTRL  = 8'h0B;
	localparam logic [7:0] IDX_REQ_ONE      = 8'h11;
	localparam logic [7:0] IDX_REQ_TWO      = 8'h12;
	localparam logic [7:0] IDX_REQ_THREE    = 8'h13;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'h21;
	localparam logic [7:0] IDX_ENABLE_ONE   = 8'h91;
	localparam logic [7:0] IDX_ENABLE_TWO   = 8'h92;
	localparam logic [7:0] IDX_ENABLE_THREE = 8'h93;

	// Implemented bits, shared by each enable and request pair
	localparam logic [7:0] IMPL_ONE   = 8'hF3;
	localparam logic [7:0] IMPL_TWO   = 8'h60;
	localparam logic [7:0] IMPL_THREE = 8'hF0;

	// Comparator bits in the second pair
	localparam int unsigned CMP_TWO_BIT = 6;
	localparam int unsigned CMP_ONE_BIT = 5;

	// Global control fields
	localparam int unsigned GLOBAL_EN_BIT = 7;
	localparam int unsigned PERIPH_EN_BIT = 6;

	// Interrupt status / mask layout: one bit per request register
	localparam int unsigned EVT_W = 3;

	// Reset values
	localparam logic [7:0]       RST_ENABLE  = 8'h00;
	localparam logic [7:0]       RST_REQUEST = 8'h00;
	localparam logic [7:0]       RST_GLOBAL  = 8'h00;
	localparam logic [EVT_W-1:0] RST_STATUS  = 3'h0;
	localparam logic [EVT_W-1:0] RST_MASK    = 3'h0;

	localparam logic [1:0] AXI_OKAY = 2'h0;

endpackage : pifb_pkg

`default_nettype wire

// [pifb_flag_reg.sv]
/*
 * One 8-bit request flag register: events set bits, software writes,
 * unimplemented bits stay zero.
 * Assumes events are single-clock-domain pulses or levels.
 */
`default_nettype none

module pifb_flag_reg #(
	parameter logic [7:0] IMPL = 8'h00
) (
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] evt_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] flag_o
);
	import pifb_pkg::*;

	logic [7:0] flag_ff;
	logic [7:0] nxt_flag;

	// Event ORed after the write: a clear never swallows an event
	assign nxt_flag = ((wr_i ? wdata_i : flag_ff) | evt_i) & IMPL;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flag_ff <= RST_REQUEST;
		end else if (ce_i) begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag_o = flag_ff;

endmodule // pifb_flag_reg

`default_nettype wire

// [tb_top.sv]
/*
 * Self-checking bench of the peripheral interrupt flag bank over AXI4-Lite.
 * Assumes pifb_pkg and pifb_top are compiled first; ADDR_W left at 12.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pifb_pkg::*;

	logic        ref_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        ce = 1'b1;
	logic [3:0]  wstrb = 4'hF;
	logic [7:0]  evt_one = 8'h00, evt_two = 8'h00, evt_three = 8'h00;
	logic        core_irq, irq;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] exp_q[$];
	int          n_errors = 0;
	int          total_checks = 0;
	logic [7:0]  idx_t[8]  = '{IDX_ENABLE_ONE, IDX_ENABLE_TWO,
		IDX_ENABLE_THREE, IDX_REQ_ONE, IDX_REQ_TWO, IDX_REQ_THREE,
		IDX_GLOBAL_CTRL, IDX_IRQ_MASK};
	logic [7:0]  impl_t[8] = '{IMPL_ONE, IMPL_TWO, IMPL_THREE, IMPL_ONE,
		IMPL_TWO, IMPL_THREE, 8'hC0, 8'h07};

	always #10 ref_clk_i = ~ref_clk_i;

	pifb_top u_pifb_top (
		.ref_clk_i       (ref_clk_i),
		.sys_rst_i       (sys_rst_i),
		.ce_i            (ce),
		.evt_one_i       (evt_one),
		.evt_two_i       (evt_two),
		.evt_three_i     (evt_three),
		.core_irq_o      (core_irq),
		.irq_o           (irq),
		.s_axi_awaddr_i  (awaddr),
		.s_axi_awvalid_i (awvalid),
		.s_axi_awready_o (awready),
		.s_axi_wdata_i   (wdata),
		.s_axi_wstrb_i   (wstrb),
		.s_axi_wvalid_i  (wvalid),
		.s_axi_wready_o  (wready),
		.s_axi_bresp_o   (bresp),
		.s_axi_bvalid_o  (bvalid),
		.s_axi_bready_i  (bready),
		.s_axi_araddr_i  (araddr),
		.s_axi_arvalid_i (arvalid),
		.s_axi_arready_o (arready),
		.s_axi_rdata_o   (rdata),
		.s_axi_rresp_o   (rresp),
		.s_axi_rvalid_o  (rvalid),
		.s_axi_rready_i  (rready)
	);

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Optional event pulse lands in the cycle the write is performed
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
			input logic [7:0] ev = 8'h00);
		int n;
		bit arm;
		n = 0;
		arm = 0;
		@(posedge ref_clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h00_0000, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
			if (arm) begin
				evt_two <= 8'h00;
				arm = 0;
			end
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
				if (ev != 8'h00) begin
					evt_two <= ev;
					arm = 1;
				end
			end
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		check({30'h0, bresp}, {30'h0, AXI_OKAY});
		bready <= 1'b0;
	endtask

	// Expected word is noted; the monitor compares at the R handshake
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		int n;
		n = 0;
		exp_q.push_back(exp);
		@(posedge ref_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		rready <= 1'b0;
	endtask

	task automatic pulse(input logic [7:0] e1, input logic [7:0] e2);
		@(posedge ref_clk_i);
		evt_one <= e1;
		evt_two <= e2;
		evt_three <= e1;
		@(posedge ref_clk_i);
		evt_one <= 8'h00;
		evt_two <= 8'h00;
		evt_three <= 8'h00;
		repeat (3) @(posedge ref_clk_i);
	endtask

	always @(posedge ref_clk_i) begin
		if (rvalid === 1'b1 && rready) begin
			check({30'h0, rresp}, {30'h0, AXI_OKAY});
			if (exp_q.size() == 0)
				check(rdata, 32'hFFFF_FFFF);
			else
				check(rdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_errors++;
		end_of_test();
	end

	initial begin
		logic [7:0] r;
		void'($urandom(32'h54e217e1));
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		foreach (idx_t[i])
			rd(ba(idx_t[i]), 32'h0000_0000);
		rd(ba(IDX_IRQ_STATUS), 32'h0000_0000);
		foreach (idx_t[i]) begin
			r = 8'($urandom);
			wr(ba(idx_t[i]), r);
			rd(ba(idx_t[i]), {24'h00_0000, r & impl_t[i]});
			wr(ba(idx_t[i]), 8'hFF);
			rd(ba(idx_t[i]), {24'h00_0000, impl_t[i]});
		end
		wr(12'h400, 8'hFF);
		rd(12'h400, 32'h0000_0000);
		rd(12'h0F0, 32'h0000_0000);
		// Low byte strobe off: the write is dropped
		wstrb <= 4'hE;
		wr(ba(IDX_ENABLE_ONE), 8'h00);
		wstrb <= 4'hF;
		rd(ba(IDX_ENABLE_ONE), {24'h00_0000, IMPL_ONE});
		foreach (idx_t[i])
			wr(ba(idx_t[i]), 8'h00);
		rd(ba(IDX_IRQ_STATUS), 32'h0000_0000);
		// Enables and globals off: flags still latch
		pulse(8'h00, 8'h60 | (8'($urandom) & 8'h9F));
		rd(ba(IDX_REQ_TWO), 32'h0000_0060);
		rd(ba(IDX_REQ_TWO), 32'h0000_0060);
		check({31'h0, core_irq}, 32'h0);
		wr(ba(IDX_ENABLE_TWO), 8'h20);
		wr(ba(IDX_GLOBAL_CTRL), 8'h80);
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, core_irq}, 32'h0);
		wr(ba(IDX_GLOBAL_CTRL), 8'hC0);
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, core_irq}, 32'h1);
		wr(ba(IDX_REQ_TWO), 8'h40);
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, core_irq}, 32'h0);
		rd(ba(IDX_REQ_TWO), 32'h0000_0040);
		// Comparator one fires in the very cycle its flag is cleared
		wr(ba(IDX_REQ_TWO), 8'h00, 8'h20);
		rd(ba(IDX_REQ_TWO), 32'h0000_0020);
		rd(ba(IDX_IRQ_STATUS), 32'h0000_0002);
		wr(ba(IDX_IRQ_MASK), 8'h02);
		pulse(8'h01, 8'h00);
		check({31'h0, irq}, 32'h0);
		pulse(8'h00, 8'h40);
		check({31'h0, irq}, 32'h1);
		rd(ba(IDX_IRQ_STATUS), 32'h0000_0003);
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, irq}, 32'h0);
		repeat (4) begin
			r = 8'($urandom);
			wr(ba(IDX_REQ_ONE), 8'h00);
			wr(ba(IDX_REQ_THREE), 8'h00);
			pulse(r, 8'h00);
			rd(ba(IDX_REQ_ONE), {24'h00_0000, r & IMPL_ONE});
			rd(ba(IDX_REQ_THREE), {24'h00_0000, r & IMPL_THREE});
		end
		// Clock enable low: an event is not even seen
		wr(ba(IDX_REQ_ONE), 8'h00);
		ce <= 1'b0;
		pulse(8'hF3, 8'h00);
		ce <= 1'b1;
		rd(ba(IDX_REQ_ONE), 32'h0000_0000);
		// Second reset mid-run clears flags and enables
		@(posedge ref_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(ba(IDX_REQ_TWO), 32'h0000_0000);
		rd(ba(IDX_ENABLE_TWO), 32'h0000_0000);
		repeat (2) @(posedge ref_clk_i);
		end_of_test();
	end

endmodule // tb_top

`default_nettype wire
